// file: shared/alert_mask_params.svh
// offsets, bit positions, reset values and masks of the alert mask block
// Operation
// - conversion-mode bit set holds the converter on one selected input
// - channel comes from bits 7:5 at 0x55; 000, 011, 100 reserved
// - shutdown bit forces every fan drive to its off level, inverted if set
// - in shutdown every current duty cycle register reads 0x00
// - lock bit set makes configuration two read-only, writes ignored
// - mask one bits 1,2,4,5,6 mask core, supply, remote one, local, remote two
// - mask one bit 7 masks every status-two out-of-limit condition
// - both mask registers reset to 0x00, all sources unmasked
// - mask two bit 1 masks thermal pin overtemp, read-only to host
// - mask two bits 2,3,4 mask fan one, two, three faults
// - mask two bit 5 masks fan four, or thermal timer when tach four is thermal
// - mask two bits 6,7 mask diode faults on remote one and two
// - shared pwm two pin is open-drain alert only when alert enable is one
`ifndef ALERT_MASK_PARAMS_SVH
`define ALERT_MASK_PARAMS_SVH

`define IDX_CHSEL        8'h55
`define IDX_CFG_TWO      8'h73
`define IDX_MASK_ONE     8'h74
`define IDX_MASK_TWO     8'h75
`define IDX_CFG_THREE    8'h78
`define IDX_CFG_ONE      8'h80
`define IDX_INT_STATUS   8'h90
`define IDX_INT_ENABLE   8'h91
`define IDX_INT_CLEAR    8'h92
`define IDX_DUTY_ONE     8'hA0
`define IDX_DUTY_TWO     8'hA1
`define IDX_DUTY_THREE   8'hA2

`define CFG1_LOCK_BIT    1
`define CFG1_INV_BIT     4
`define CFG1_T4THERM_BIT 5
`define CFG1_WMASK       8'h32
`define CFG2_SINGLE_CHANNEL_MODE_BIT    6
`define CFG2_SHUTDOWN_REQUEST_BIT    7
`define CFG3_ALERT_BIT   0
`define CHSEL_MSB        7
`define CHSEL_LSB        5
`define MASK1_OOL_BIT    7
`define MASK1_WMASK      8'hF6
`define MASK2_WMASK      8'hFC
`define MASK2_ROMASK     8'h02

`define RST_CFG          8'h00
`define RST_CHSEL        8'h00
`define RST_MASK         8'h00
`define RST_INT          12'h000

`endif

// file: shared/alert_mask_pkg.sv
// types shared by the alert mask block
package alert_mask_pkg;

    typedef enum logic [2:0] {
        CH_RSVD_A = 3'b000,
        CH_CORE_V = 3'b001,
        CH_SUPPLY = 3'b010,
        CH_RSVD_B = 3'b011,
        CH_RSVD_C = 3'b100,
        CH_REM1_T = 3'b101,
        CH_LOCAL  = 3'b110,
        CH_REM2_T = 3'b111
    } adc_channel_e;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_e;

    typedef logic [7:0]  reg8_t;
    typedef logic [11:0] cond_t;

endpackage : alert_mask_pkg

// file: src/alert_mask_ctrl.sv
// alert masking, conversion control and axi4-lite register file
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_params.svh"

module alert_mask_ctrl
    import alert_mask_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // axi4-lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // axi4-lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // fault conditions from pins
    input  wire logic [4:0]        volt_temp_fault,
    input  wire logic              overtemp_fault,
    input  wire logic [3:0]        fan_fault,
    input  wire logic [1:0]        diode_fault,
    input  wire logic              thermal_timer_event,
    // pwm generator, same clock
    input  wire logic [2:0]        pwm_raw,
    input  wire logic [2:0][7:0]   duty_in,
    // fan drive and shared alert pin
    output logic                   fan_pwm_one,
    output logic                   fan_pwm_three,
    output logic                   pwm2_alert_o,
    output logic                   pwm2_alert_oe,
    // converter control
    output logic                   adc_single_mode,
    output logic [2:0]             adc_channel_sel,
    output logic                   shutdown_active,
    // interrupt
    output logic                   irq
);

    localparam int IW = ADDR_W - 2;

    // synchronised conditions
    logic [12:0] fault_sync;

    sync_two_ff #(
        .WIDTH (13)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({thermal_timer_event, diode_fault, fan_fault,
                   overtemp_fault, volt_temp_fault}),
        .dout    (fault_sync)
    );

    // bus state
    logic          aw_hold_reg, aw_hold_next;
    logic [IW-1:0] aw_idx_reg, aw_idx_next;
    logic          w_hold_reg, w_hold_next;
    logic [11:0]   w_data_reg, w_data_next;
    logic [1:0]    w_strb_reg, w_strb_next;
    logic          awready_next, wready_next;
    logic          bvalid_next, arready_next, rvalid_next;
    logic [1:0]    bresp_next, rresp_next;
    logic [31:0]   rdata_next;
    logic          wr_go;
    logic          wr_hit;
    logic          rd_hit;
    logic [11:0]   rd_val;

    // register state
    reg8_t         cfg_one_reg, cfg_one_next;
    reg8_t         cfg_two_reg, cfg_two_next;
    reg8_t         cfg_three_reg, cfg_three_next;
    reg8_t         chsel_reg, chsel_next;
    reg8_t         mask_one_reg, mask_one_next;
    reg8_t         mask_two_reg, mask_two_next;
    cond_t         int_status_reg, int_status_next;
    cond_t         int_en_reg, int_en_next;
    cond_t         cond_prev_reg;
    cond_t         wmask12;

    // output state
    logic          fan_pwm_one_next, fan_pwm_three_next;
    logic          pwm2_alert_o_next, pwm2_alert_oe_next;
    logic          adc_single_mode_next, shutdown_active_next;
    logic [2:0]    adc_channel_sel_next;
    logic          irq_next;

    // derived controls
    logic          locked;
    logic          shutdown_request;
    logic          pwm_polarity_invert;
    logic          single_channel_mode;
    logic          chan_valid;
    adc_channel_e  chan;
    cond_t         cond;
    cond_t         mask_vec;
    logic          alert_active;

    assign locked = cfg_one_reg[`CFG1_LOCK_BIT];
    assign shutdown_request   = cfg_two_reg[`CFG2_SHUTDOWN_REQUEST_BIT];
    assign pwm_polarity_invert    = cfg_one_reg[`CFG1_INV_BIT];
    assign single_channel_mode = cfg_two_reg[`CFG2_SINGLE_CHANNEL_MODE_BIT];
    assign chan   = adc_channel_e'(chsel_reg[`CHSEL_MSB:`CHSEL_LSB]);

    // reserved codes leave the converter cycling
    always_comb begin
        unique case (chan)
            CH_CORE_V, CH_SUPPLY, CH_REM1_T, CH_LOCAL, CH_REM2_T:
                chan_valid = 1'b1;
            default:
                chan_valid = 1'b0;
        endcase
    end

    // status-two conditions sit in bits 11:5
    always_comb begin
        cond = {fault_sync[11:10],
                cfg_one_reg[`CFG1_T4THERM_BIT] ? fault_sync[12]
                                               : fault_sync[9],
                fault_sync[8:6], fault_sync[5], fault_sync[4:0]};
        mask_vec = {mask_two_reg[7:6],
                    mask_two_reg[5],
                    mask_two_reg[4:2],
                    mask_two_reg[1],
                    mask_one_reg[6:4],
                    mask_one_reg[2:1]};
        if (mask_one_reg[`MASK1_OOL_BIT]) begin
            mask_vec[11:5] = 7'h7F;
        end
        alert_active = |(cond & ~mask_vec);
    end

    // read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 12'h000;
        unique case (araddr[ADDR_W-1:2])
            IW'(`IDX_CFG_ONE):    rd_val = {4'h0, cfg_one_reg};
            IW'(`IDX_CFG_TWO):    rd_val = {4'h0, cfg_two_reg};
            IW'(`IDX_CFG_THREE):  rd_val = {4'h0, cfg_three_reg};
            IW'(`IDX_CHSEL):      rd_val = {4'h0, chsel_reg};
            IW'(`IDX_MASK_ONE):   rd_val = {4'h0, mask_one_reg};
            IW'(`IDX_MASK_TWO):   rd_val = {4'h0, mask_two_reg};
            IW'(`IDX_INT_STATUS): rd_val = int_status_reg;
            IW'(`IDX_INT_ENABLE): rd_val = int_en_reg;
            IW'(`IDX_INT_CLEAR):  rd_val = 12'h000;
            IW'(`IDX_DUTY_ONE):   rd_val = shutdown_request ? 12'h000 : {4'h0, duty_in[0]};
            IW'(`IDX_DUTY_TWO):   rd_val = shutdown_request ? 12'h000 : {4'h0, duty_in[1]};
            IW'(`IDX_DUTY_THREE): rd_val = shutdown_request ? 12'h000 : {4'h0, duty_in[2]};
            default:              rd_hit = 1'b0;
        endcase
    end

    // write decode
    always_comb begin
        unique case (aw_idx_reg)
            IW'(`IDX_CFG_ONE), IW'(`IDX_CFG_TWO), IW'(`IDX_CFG_THREE),
            IW'(`IDX_CHSEL), IW'(`IDX_MASK_ONE), IW'(`IDX_MASK_TWO),
            IW'(`IDX_INT_STATUS), IW'(`IDX_INT_ENABLE),
            IW'(`IDX_INT_CLEAR), IW'(`IDX_DUTY_ONE),
            IW'(`IDX_DUTY_TWO), IW'(`IDX_DUTY_THREE):
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // address and data may arrive in either order
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_idx_next  = aw_idx_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid;
        bresp_next   = bresp;
        rvalid_next  = rvalid;
        rresp_next   = rresp;
        rdata_next   = rdata;
        wr_go        = aw_hold_reg & w_hold_reg & ~bvalid;
        if (awvalid && awready) begin
            aw_hold_next = 1'b1;
            aw_idx_next  = awaddr[ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            w_hold_next = 1'b1;
            w_data_next = wdata[11:0];
            w_strb_next = wstrb[1:0];
        end
        if (bvalid && bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_go) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rdata_next  = {20'h0_0000, rd_val};
            rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        awready_next = ~aw_hold_next & ~bvalid_next;
        wready_next  = ~w_hold_next & ~bvalid_next;
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_idx_reg  <= '0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 12'h000;
            w_strb_reg  <= 2'h0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
            rresp       <= RESP_OKAY;
            rdata       <= 32'h0000_0000;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_idx_reg  <= aw_idx_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            awready     <= awready_next;
            wready      <= wready_next;
            bvalid      <= bvalid_next;
            bresp       <= bresp_next;
            arready     <= arready_next;
            rvalid      <= rvalid_next;
            rresp       <= rresp_next;
            rdata       <= rdata_next;
        end
    end

    // register file; byte lane 0 carries every 8-bit register
    always_comb begin
        cfg_one_next    = cfg_one_reg;
        cfg_two_next    = cfg_two_reg;
        cfg_three_next  = cfg_three_reg;
        chsel_next      = chsel_reg;
        mask_one_next   = mask_one_reg;
        mask_two_next   = mask_two_reg;
        int_en_next     = int_en_reg;
        wmask12         = {{4{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
        // sticky events; a set in the clear cycle survives
        int_status_next = int_status_reg | (cond & ~cond_prev_reg);
        if (wr_go && w_strb_reg[0]) begin
            unique case (aw_idx_reg)
                IW'(`IDX_CFG_ONE):
                    // lock stays set until reset
                    cfg_one_next = (w_data_reg[7:0] & `CFG1_WMASK)
                                 | (cfg_one_reg & 8'h02);
                IW'(`IDX_CFG_TWO):
                    if (!locked) begin
                        cfg_two_next = w_data_reg[7:0];
                    end
                IW'(`IDX_CFG_THREE):
                    if (!locked) begin
                        cfg_three_next = w_data_reg[7:0];
                    end
                IW'(`IDX_CHSEL):
                    chsel_next = w_data_reg[7:0];
                IW'(`IDX_MASK_ONE):
                    mask_one_next = w_data_reg[7:0] & `MASK1_WMASK;
                IW'(`IDX_MASK_TWO):
                    mask_two_next = (w_data_reg[7:0] & `MASK2_WMASK)
                                  | (mask_two_reg & `MASK2_ROMASK);
                default: ;
            endcase
        end
        if (wr_go && aw_idx_reg == IW'(`IDX_INT_ENABLE)) begin
            int_en_next = (w_data_reg & wmask12) | (int_en_reg & ~wmask12);
        end
        if (wr_go && aw_idx_reg == IW'(`IDX_INT_CLEAR)) begin
            int_status_next = int_status_next
                            & ~(w_data_reg & wmask12 & ~(cond & ~cond_prev_reg));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_one_reg    <= `RST_CFG;
            cfg_two_reg    <= `RST_CFG;
            cfg_three_reg  <= `RST_CFG;
            chsel_reg      <= `RST_CHSEL;
            mask_one_reg   <= `RST_MASK;
            mask_two_reg   <= `RST_MASK;
            int_status_reg <= `RST_INT;
            int_en_reg     <= `RST_INT;
            cond_prev_reg  <= `RST_INT;
        end else begin
            cfg_one_reg    <= cfg_one_next;
            cfg_two_reg    <= cfg_two_next;
            cfg_three_reg  <= cfg_three_next;
            chsel_reg      <= chsel_next;
            mask_one_reg   <= mask_one_next;
            mask_two_reg   <= mask_two_next;
            int_status_reg <= int_status_next;
            int_en_reg     <= int_en_next;
            cond_prev_reg  <= cond;
        end
    end

    // pin and converter outputs
    always_comb begin
        adc_single_mode_next = single_channel_mode & chan_valid;
        adc_channel_sel_next = chsel_reg[`CHSEL_MSB:`CHSEL_LSB];
        shutdown_active_next = shutdown_request;
        fan_pwm_one_next     = shutdown_request ? pwm_polarity_invert : pwm_raw[0];
        fan_pwm_three_next   = shutdown_request ? pwm_polarity_invert : pwm_raw[2];
        if (cfg_three_reg[`CFG3_ALERT_BIT]) begin
            // open drain: only ever pulls low
            pwm2_alert_o_next  = 1'b0;
            pwm2_alert_oe_next = alert_active;
        end else begin
            pwm2_alert_o_next  = shutdown_request ? pwm_polarity_invert : pwm_raw[1];
            pwm2_alert_oe_next = 1'b1;
        end
        irq_next = |(int_status_reg & int_en_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_single_mode <= 1'b0;
            adc_channel_sel <= 3'h0;
            shutdown_active <= 1'b0;
            fan_pwm_one     <= 1'b0;
            fan_pwm_three   <= 1'b0;
            pwm2_alert_o    <= 1'b0;
            pwm2_alert_oe   <= 1'b0;
            irq             <= 1'b0;
        end else begin
            adc_single_mode <= adc_single_mode_next;
            adc_channel_sel <= adc_channel_sel_next;
            shutdown_active <= shutdown_active_next;
            fan_pwm_one     <= fan_pwm_one_next;
            fan_pwm_three   <= fan_pwm_three_next;
            pwm2_alert_o    <= pwm2_alert_o_next;
            pwm2_alert_oe   <= pwm2_alert_oe_next;
            irq             <= irq_next;
        end
    end

endmodule : alert_mask_ctrl

`default_nettype wire

// file: src/sync_two_ff.sv
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] dout_next;

    always_comb begin
        meta_next = din;
        dout_next = meta_reg;
    end

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= meta_next;
            dout     <= dout_next;
        end
    end

endmodule : sync_two_ff

`default_nettype wire

// file: tb/alert_mask_checker_assertions.sv
// concurrent checks on the ports of the alert mask block
`timescale 1ns/1ps
`default_nettype none

module alert_mask_checker
    import alert_mask_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // fan drive and converter
    input wire logic [2:0]  pwm_raw,
    input wire logic        fan_pwm_one,
    input wire logic        fan_pwm_three,
    input wire logic        adc_single_mode,
    input wire logic [2:0]  adc_channel_sel,
    input wire logic        shutdown_active
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rd_taken;
        arvalid && arready;
    endsequence

    chk_write_answer: assert property (wr_taken |-> ##[1:2] bvalid)
        else $error("write response late");
    chk_read_answer: assert property (rd_taken |=> rvalid)
        else $error("read data late");
    chk_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    chk_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    chk_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0000_0000)
        else $error("refused read returns data");
    // reserved codes must keep the converter cycling
    chk_channel_valid: assert property (adc_single_mode |->
        adc_channel_sel inside {3'b001, 3'b010, 3'b101, 3'b110, 3'b111})
        else $error("single mode on reserved channel");
    chk_shutdown_request_off_level: assert property (shutdown_active |-> fan_pwm_one == fan_pwm_three)
        else $error("fan outputs differ in shutdown");
    chk_pwm_follows: assert property ($past(aresetn) && !shutdown_active |->
        fan_pwm_one == $past(pwm_raw[0]) && fan_pwm_three == $past(pwm_raw[2]))
        else $error("fan drive not following generator");
endmodule : alert_mask_checker

bind alert_mask_ctrl alert_mask_checker u_chk (.*);

`default_nettype wire

// file: tb/axil_host_model.sv
// register bus master standing in for the host
`timescale 1ns/1ps
`default_nettype none

module axil_host_model (
    // clock
    input wire logic         aclk,
    // write channels
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input wire logic         awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input wire logic         wready,
    input wire logic [1:0]   bresp,
    input wire logic         bvalid,
    output logic             bready,
    // read channels
    output logic [11:0]      araddr,
    output logic             arvalid,
    input wire logic         arready,
    input wire logic [31:0]  rdata,
    input wire logic [1:0]   rresp,
    input wire logic         rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // byte address is four times the word index
    task automatic do_write(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= d;
        wstrb   <= 4'h3;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : do_write

    task automatic do_read(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : do_read
endmodule : axil_host_model

`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the alert mask block
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_params.svh"

module tb_top
    import alert_mask_pkg::*;
;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    wire [11:0]       awaddr, araddr;
    wire [31:0]       wdata;
    wire [3:0]        wstrb;
    wire              awvalid, wvalid, bready, arvalid, rready;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    logic [11:0]      cond = '0;
    logic             timer_ev = 1'b0;
    logic [2:0]       pwm_raw = '0;
    logic [2:0][7:0]  duty = '0;
    logic             fan_pwm_one, fan_pwm_three, pwm2_alert_o, pwm2_alert_oe;
    logic             adc_single_mode, shutdown_active, irq;
    logic [2:0]       adc_channel_sel;
    integer           seed = 60507;
    int               bad_count = 0;
    int               n_tests = 0;
    int               cycles = 0;
    logic [7:0]       v;

    always #5 aclk = ~aclk;

    alert_mask_ctrl u_dut (.*, .volt_temp_fault(cond[4:0]), .overtemp_fault(cond[5]),
        .fan_fault(cond[9:6]), .diode_fault(cond[11:10]), .thermal_timer_event(timer_ev),
        .duty_in(duty));

    axil_host_model u_host (.*);

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er = 2'b00);
        logic [1:0] r;
        u_host.do_write(idx, d, r);
        chk(r, er);
    endtask : wr

    task automatic rexp(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er = 2'b00);
        logic [31:0] d;
        logic [1:0]  r;
        u_host.do_read(idx, d, r);
        chk(d, e);
        chk(r, er);
    endtask : rexp

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : tick

    // mask bit guarding condition i; 5 uses the status-two bit in mask one, 6 and up a bit of mask two
    function automatic int mask_bit(input int i);
        if (i < 2) return i + 1;
        if (i < 5) return i + 2;
        if (i < 6) return 7;
        return i - 4;
    endfunction : mask_bit

    function automatic logic chan_ok(input logic [2:0] c);
        return !(c inside {3'b000, 3'b011, 3'b100});
    endfunction : chan_ok

    // pwm generator level is redrawn at random every cycle so a stuck fan drive shows
    always @(posedge aclk) begin
        pwm_raw <= 3'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        duty <= 24'($random(seed));
        tick(2);
        rexp(`IDX_MASK_ONE, 0);
        rexp(`IDX_MASK_TWO, 0);
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'hFF : 8'($random(seed));
            wr(`IDX_MASK_ONE, v);
            rexp(`IDX_MASK_ONE, v & `MASK1_WMASK);
            wr(`IDX_MASK_TWO, v);
            rexp(`IDX_MASK_TWO, v & `MASK2_WMASK);
        end
        wr(`IDX_MASK_ONE, 0);
        wr(`IDX_MASK_TWO, 0);
        wr(`IDX_INT_ENABLE, 32'h0000_0FFF);
        wr(`IDX_CFG_THREE, 1);
        tick(3);
        chk(pwm2_alert_oe, 0);
        for (int i = 0; i < 12; i++) begin
            @(posedge aclk) cond[i] <= 1'b1;
            tick(6);
            chk({pwm2_alert_oe, pwm2_alert_o}, 2'b10);
            chk(irq, 1);
            rexp(`IDX_INT_STATUS, 1 << i);
            wr((i < 6) ? `IDX_MASK_ONE : `IDX_MASK_TWO, 1 << mask_bit(i));
            tick(3);
            chk(pwm2_alert_oe, 0);
            if (i >= 6) begin
                wr(`IDX_MASK_TWO, 0);
                wr(`IDX_MASK_ONE, 8'h80);
                tick(3);
                chk(pwm2_alert_oe, 0);
            end
            wr(`IDX_MASK_ONE, 0);
            wr(`IDX_MASK_TWO, 0);
            @(posedge aclk) cond[i] <= 1'b0;
            tick(4);
            wr(`IDX_INT_CLEAR, 1 << i);
            tick(2);
            chk(irq, 0);
        end
        // disabled source keeps irq low although status is set
        wr(`IDX_INT_ENABLE, 0);
        @(posedge aclk) cond[0] <= 1'b1;
        tick(6);
        chk(irq, 0);
        rexp(`IDX_INT_STATUS, 1);
        wr(`IDX_INT_ENABLE, 1);
        tick(2);
        chk(irq, 1);
        wr(`IDX_INT_CLEAR, 1);
        tick(2);
        chk(irq, 0);
        rexp(`IDX_INT_STATUS, 0);
        @(posedge aclk) cond[0] <= 1'b0;
        // tach four as thermal input: timer event takes the fan four bit
        wr(`IDX_CFG_ONE, 8'h20);
        @(posedge aclk) timer_ev <= 1'b1;
        tick(6);
        rexp(`IDX_INT_STATUS, 32'h0000_0200);
        chk({pwm2_alert_oe, pwm2_alert_o}, 2'b10);
        wr(`IDX_MASK_TWO, 8'h20);
        tick(3);
        chk(pwm2_alert_oe, 0);
        @(posedge aclk) timer_ev <= 1'b0;
        wr(`IDX_MASK_TWO, 0);
        wr(`IDX_INT_CLEAR, 32'h0000_0200);
        wr(`IDX_CFG_THREE, 0);
        tick(3);
        chk(pwm2_alert_oe, 1);
        wr(`IDX_CFG_TWO, 8'h40);
        for (int c = 0; c < 8; c++) begin
            wr(`IDX_CHSEL, c << 5);
            tick(2);
            chk(adc_single_mode, chan_ok(3'(c)));
            if (chan_ok(3'(c))) chk(adc_channel_sel, c);
            rexp(`IDX_CHSEL, c << 5);
        end
        wr(`IDX_CFG_TWO, 0);
        tick(2);
        chk(adc_single_mode, 0);
        for (int j = 0; j < 3; j++) rexp(10'(`IDX_DUTY_ONE + j), duty[j]);
        wr(`IDX_CFG_TWO, 8'h80);
        tick(2);
        chk({shutdown_active, fan_pwm_one, fan_pwm_three, pwm2_alert_o}, 4'b1000);
        for (int j = 0; j < 3; j++) rexp(10'(`IDX_DUTY_ONE + j), 0);
        wr(`IDX_CFG_ONE, 8'h10);
        tick(2);
        chk({fan_pwm_one, fan_pwm_three, pwm2_alert_o}, 3'b111);
        wr(`IDX_CFG_ONE, 8'h12);
        wr(`IDX_CFG_TWO, 0);
        rexp(`IDX_CFG_TWO, 8'h80);
        tick(2);
        chk(shutdown_active, 1);
        wr(10'h3FF, 1, RESP_SLVERR);
        rexp(10'h3FF, 0, RESP_SLVERR);
        wr(`IDX_MASK_ONE, 8'hF6);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        rexp(`IDX_MASK_ONE, 0);
        rexp(`IDX_CFG_TWO, 0);
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
